// ---- common/video_in_params.svh ----
`ifndef VIDEO_IN_PARAMS_SVH
`define VIDEO_IN_PARAMS_SVH
`define PIXEL_WIDTH        24
`define BLUE_LSB           0
`define GREEN_LSB          8
`define RED_LSB            16
`define COLOR_WIDTH        8
`define RELOAD_FRAMES      5
`define ACTIVE_PIXELS      1024
`define ACTIVE_LINES       768
`define VBLANK_MIN_LINES   22
`define VBLANK_MAX_LINES   240
`define HSYNC_MIN_CLKS     20
`define HSYNC_MAX_CLKS     500
`define ADDR_BASE          7'h30
`endif

// ---- common/video_in_pkg.sv ----
package video_in_pkg;
    typedef enum logic [1:0] {
        ST_RESET,
        ST_RELOAD,
        ST_READY
    } power_state_t;
    typedef logic [23:0] pixel_t;
endpackage

// ---- rtl/video_in.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "video_in_params.svh"
module video_in
    import video_in_pkg::*;
#(
    parameter int DEPTH = 2
) (
    // system
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // link pins
    input  wire logic        i_pixel_clock,
    input  wire logic        i_reset_n,
    input  wire logic [23:0] i_pixel_bus,
    input  wire logic        i_pixel_valid,
    input  wire logic        i_hsync,
    input  wire logic        i_i2c_addr_select,
    // pixel stream out
    output logic [7:0]       o_red,
    output logic [7:0]       o_green,
    output logic [7:0]       o_blue,
    output logic             o_valid,
    output logic             o_line_start,
    input  wire logic        i_ready,
    // status
    output logic             o_settings_ready,
    output logic             o_overflow,
    output logic [6:0]       o_i2c_addr
);
    // pixel clock domain: reset pin synchronised, async assert
    logic       prst_m_q;
    logic       prst_q;
    always_ff @(posedge i_pixel_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prst_m_q <= 1'b1;
            prst_q   <= 1'b1;
        end else begin
            prst_m_q <= 1'b0;
            prst_q   <= prst_m_q;
        end
    end

    // sampled on rising pixel clock edge
    pixel_t     pix_q;
    logic       pval_q;
    logic       hs_q;
    logic       hs_prev_q;
    always_ff @(posedge i_pixel_clock or posedge prst_q) begin
        if (prst_q) begin
            pix_q     <= '0;
            pval_q    <= 1'b0;
            hs_q      <= 1'b0;
            hs_prev_q <= 1'b0;
        end else begin
            pix_q     <= i_pixel_bus;
            pval_q    <= i_pixel_valid;
            hs_q      <= i_hsync;
            hs_prev_q <= hs_q;
        end
    end
    wire line_rise = hs_q && !hs_prev_q;

    // line counter: frame boundary at the first line without pixels after active lines
    logic [11:0] line_cnt_q;
    logic        line_had_px_q;
    logic [8:0]  blank_cnt_q;
    logic        frame_tick_q;
    always_ff @(posedge i_pixel_clock or posedge prst_q) begin
        if (prst_q) begin
            line_cnt_q    <= '0;
            line_had_px_q <= 1'b0;
            blank_cnt_q   <= '0;
            frame_tick_q  <= 1'b0;
        end else begin
            frame_tick_q <= 1'b0;
            if (pval_q) begin
                line_had_px_q <= 1'b1;
            end
            if (line_rise) begin
                line_had_px_q <= 1'b0;
                if (line_had_px_q) begin
                    line_cnt_q  <= line_cnt_q + 12'h001;
                    blank_cnt_q <= '0;
                end else begin
                    if (blank_cnt_q != 9'h1ff) begin
                        blank_cnt_q <= blank_cnt_q + 9'h001;
                    end
                    // first blank line after active video closes a frame
                    if (line_cnt_q != 12'h000) begin
                        frame_tick_q <= 1'b1;
                        line_cnt_q   <= '0;
                    end
                end
            end
        end
    end

    // frame event toggle across to system clock
    logic frame_tgl_q;
    always_ff @(posedge i_pixel_clock or posedge prst_q) begin
        if (prst_q) begin
            frame_tgl_q <= 1'b0;
        end else if (frame_tick_q) begin
            frame_tgl_q <= ~frame_tgl_q;
        end
    end

    // pixel words cross by gray pointers into a small async buffer
    localparam int AW = 2;
    logic [23:0]   mem [0:(1<<AW)-1];
    logic [AW:0]   wbin_q;
    logic [AW:0]   wgray_q;
    logic [AW:0]   rgray_m_q;
    logic [AW:0]   rgray_s_q;
    logic [AW:0]   rbin_q;
    logic [AW:0]   rgray_q;
    logic [AW:0]   wgray_m_q;
    logic [AW:0]   wgray_s_q;
    logic          ovf_tgl_q;
    wire  [AW:0]   wbin_n  = wbin_q + 3'h1;
    wire  [AW:0]   wgray_n = wbin_n ^ (wbin_n >> 1);
    wire           afull   = (wgray_q == {~rgray_s_q[AW:AW-1], rgray_s_q[AW-2:0]});
    wire           push    = pval_q;

    always_ff @(posedge i_pixel_clock) begin
        if (push && !afull) begin
            mem[wbin_q[AW-1:0]] <= pix_q;
        end
    end
    always_ff @(posedge i_pixel_clock or posedge prst_q) begin
        if (prst_q) begin
            wbin_q    <= '0;
            wgray_q   <= '0;
            rgray_m_q <= '0;
            rgray_s_q <= '0;
            ovf_tgl_q <= 1'b0;
        end else begin
            rgray_m_q <= rgray_q;
            rgray_s_q <= rgray_m_q;
            if (push && !afull) begin
                wbin_q  <= wbin_n;
                wgray_q <= wgray_n;
            end else if (push) begin
                ovf_tgl_q <= ~ovf_tgl_q;
            end
        end
    end

    // system domain: synchronisers
    logic       rst_link_m_q;
    logic       rst_link_q;
    logic [2:0] ftgl_q;
    logic [2:0] otgl_q;
    // address select is a pin: two flops before use
    logic       addr_m_q;
    logic       addr_s_q;
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            addr_m_q <= 1'b0;
            addr_s_q <= 1'b0;
        end else begin
            addr_m_q <= i_i2c_addr_select;
            addr_s_q <= addr_m_q;
        end
    end
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rst_link_m_q <= 1'b1;
            rst_link_q   <= 1'b1;
            ftgl_q       <= '0;
            otgl_q       <= '0;
            wgray_m_q    <= '0;
            wgray_s_q    <= '0;
        end else begin
            rst_link_m_q <= ~i_reset_n;
            rst_link_q   <= rst_link_m_q;
            ftgl_q       <= {ftgl_q[1:0], frame_tgl_q};
            otgl_q       <= {otgl_q[1:0], ovf_tgl_q};
            wgray_m_q    <= wgray_q;
            wgray_s_q    <= wgray_m_q;
        end
    end
    wire frame_evt = ftgl_q[2] ^ ftgl_q[1];

    // settings reload wait
    power_state_t st_q;
    logic [2:0]   fcnt_q;
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st_q   <= ST_RESET;
            fcnt_q <= '0;
        end else if (rst_link_q) begin
            st_q   <= ST_RESET;
            fcnt_q <= '0;
        end else begin
            unique case (st_q)
                ST_RESET: st_q <= ST_RELOAD;
                ST_RELOAD: begin
                    if (frame_evt) begin
                        fcnt_q <= fcnt_q + 3'h1;
                        if (fcnt_q == 3'(`RELOAD_FRAMES - 1)) begin
                            st_q <= ST_READY;
                        end
                    end
                end
                ST_READY: st_q <= ST_READY;
            endcase
        end
    end

    // read side: two-entry output skid stage driven from the async buffer
    wire           rempty = (rgray_q == wgray_s_q);
    logic [23:0]   ob_q [0:DEPTH-1];
    logic [1:0]    ocnt_q;
    wire           pop     = !rempty && (ocnt_q < 2'(DEPTH));
    wire           out_fire = o_valid && i_ready;
    wire  [AW:0]   rbin_n  = rbin_q + 3'h1;
    // next head word, so colours leave together with valid
    pixel_t        ob0_d;
    always_comb begin
        ob0_d = ob_q[0];
        if (out_fire) begin
            ob0_d = ob_q[1];
        end
        if (pop && (ocnt_q == 2'h0 || (ocnt_q == 2'h1 && out_fire))) begin
            ob0_d = mem[rbin_q[AW-1:0]];
        end
    end
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rbin_q           <= '0;
            rgray_q          <= '0;
            ocnt_q           <= '0;
            ob_q[0]          <= '0;
            ob_q[1]          <= '0;
            o_valid          <= 1'b0;
            o_red            <= '0;
            o_green          <= '0;
            o_blue           <= '0;
            o_line_start     <= 1'b0;
            o_settings_ready <= 1'b0;
            o_overflow       <= 1'b0;
            o_i2c_addr       <= '0;
        end else begin
            if (pop) begin
                rbin_q  <= rbin_n;
                rgray_q <= rbin_n ^ (rbin_n >> 1);
            end
            if (out_fire) begin
                ob_q[0] <= ob_q[1];
            end
            if (pop) begin
                if (ocnt_q == 2'h0 || (ocnt_q == 2'h1 && out_fire)) begin
                    ob_q[0] <= mem[rbin_q[AW-1:0]];
                end else begin
                    ob_q[1] <= mem[rbin_q[AW-1:0]];
                end
            end
            ocnt_q <= ocnt_q + {1'b0, pop} - {1'b0, out_fire};
            o_valid <= 1'b0;
            if ((ocnt_q - {1'b0, out_fire} + {1'b0, pop}) != 2'h0) begin
                o_valid <= 1'b1;
            end
            o_blue           <= ob0_d[`BLUE_LSB +: `COLOR_WIDTH];
            o_green          <= ob0_d[`GREEN_LSB +: `COLOR_WIDTH];
            o_red            <= ob0_d[`RED_LSB +: `COLOR_WIDTH];
            o_line_start     <= frame_evt;
            o_settings_ready <= (st_q == ST_READY);
            if (otgl_q[2] ^ otgl_q[1]) begin
                o_overflow <= 1'b1;
            end
            o_i2c_addr <= `ADDR_BASE | {6'h00, addr_s_q};
        end
    end

    reload_wait_a: assert property (@(posedge i_clock) disable iff (i_rst)
        $rose(o_settings_ready) |-> $past(fcnt_q) == 3'(`RELOAD_FRAMES))
        else $error("settings ready before reload frames");
    reset_holds_a: assert property (@(posedge i_clock) disable iff (i_rst)
        rst_link_q |=> st_q == ST_RESET)
        else $error("state left reset while pin low");
    valid_only_a: assert property (@(posedge i_pixel_clock) disable iff (prst_q)
        $changed(wbin_q) |-> $past(pval_q))
        else $error("pixel stored without valid");
    output_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
        o_valid && !i_ready |=> o_valid && $stable({o_red, o_green, o_blue}))
        else $error("stalled word changed");
    overflow_sticky_a: assert property (@(posedge i_clock) disable iff (i_rst)
        o_overflow |=> o_overflow)
        else $error("overflow flag dropped");
    depth_bound_a: assert property (@(posedge i_clock) disable iff (i_rst)
        ocnt_q <= 2'(DEPTH))
        else $error("output stage over depth");
    frame_clear_a: assert property (@(posedge i_pixel_clock) disable iff (prst_q)
        frame_tick_q |-> line_cnt_q == 12'h000)
        else $error("line count kept after frame end");
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "video_in_params.svh"
module tb_top;
    import video_in_pkg::*;
    logic       i_clock, i_rst, pclk, reset_n, pix_valid, hsync, addr_sel, ready;
    pixel_t     pix_bus;
    logic [7:0] red, green, blue;
    logic       valid, line_start, settings_ready, overflow;
    logic [6:0] i2c_addr;
    int         n_errors = 0;
    int         checked = 0;
    int         frames = 0;
    pixel_t     got[$];

    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    // unrelated phase on purpose
    initial begin
        pclk = 1'b0;
        #3.7;
        forever #6 pclk = ~pclk;
    end

    video_host #(.NPIX(16), .NLINES(2)) u_host (.i_pixel_clock(pclk), .o_reset_n(reset_n),
        .o_pixel_bus(pix_bus), .o_pixel_valid(pix_valid), .o_hsync(hsync));
    video_in u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_pixel_clock(pclk),
        .i_reset_n(reset_n), .i_pixel_bus(pix_bus), .i_pixel_valid(pix_valid),
        .i_hsync(hsync), .i_i2c_addr_select(addr_sel), .o_red(red), .o_green(green),
        .o_blue(blue), .o_valid(valid), .o_line_start(line_start), .i_ready(ready),
        .o_settings_ready(settings_ready), .o_overflow(overflow), .o_i2c_addr(i2c_addr));

    always @(posedge i_clock) begin
        if (valid === 1'b1 && ready === 1'b1) got.push_back({red, green, blue});
        if (line_start === 1'b1) frames++;
    end

    function automatic pixel_t exp_pix(input int k);
        return {~8'(k), 8'(k) ^ 8'h5a, 8'(k)};
    endfunction
    task automatic wait_sys(input int n);
        repeat (n) @(negedge i_clock);
    endtask
    task automatic check(input logic c, input string msg);
        checked++;
        if (c !== 1'b1) begin
            n_errors++;
            $display("ERROR at %0t: %s", $time, msg);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic t_reset();
        wait_sys(2);
        check(valid === 1'b0 && settings_ready === 1'b0 && overflow === 1'b0, "reset");
        i_rst = 1'b0;
        wait_sys(20);
        check(valid === 1'b0 && settings_ready === 1'b0, "held by reset pin");
        $display("t_reset done");
    endtask
    task automatic t_reload();
        u_host.power_up();
        for (int s = 0; s < 2; s++) begin
            addr_sel = s[0];
            wait_sys(8);
            check(i2c_addr === (`ADDR_BASE | 7'(s)), "address select");
        end
        ready = 1'b1;
        frames = 0;
        repeat (4) u_host.send_frame();
        wait_sys(20);
        check(settings_ready === 1'b0 && frames == 4, "ready too early");
        u_host.send_frame();
        wait_sys(20);
        check(settings_ready === 1'b1 && frames == 5, "reload after five frames");
        $display("t_reload done");
    endtask
    task automatic t_stream();
        wait_sys(40);
        got.delete();
        repeat (2) u_host.send_line(16);
        wait_sys(40);
        check(got.size() == 32, "pixel count");
        foreach (got[i]) check(got[i] === exp_pix(i % 16), "colour map");
        $display("t_stream done");
    endtask
    // sink stalls while a line arrives: the front of the line must survive
    task automatic t_stall();
        ready = 1'b0;
        wait_sys(2);
        got.delete();
        u_host.send_line(12);
        wait_sys(40);
        check(overflow === 1'b1 && valid === 1'b1, "full buffer");
        ready = 1'b1;
        wait_sys(40);
        check(got.size() >= 4 && got.size() < 12, "kept words");
        foreach (got[i]) check(got[i] === exp_pix(i), "order after stall");
        $display("t_stall done");
    endtask

    initial begin
        i_rst = 1'b1;
        addr_sel = 1'b0;
        ready = 1'b0;
        t_reset();
        t_reload();
        t_stream();
        t_stall();
        give_verdict();
    end
    initial begin
        #400000;
        n_errors++;
        $display("ERROR at %0t: watchdog", $time);
        give_verdict();
    end
endmodule
`default_nettype wire

// ---- sim/video_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "video_in_params.svh"
module video_host #(
    parameter int NPIX     = `ACTIVE_PIXELS,
    parameter int NLINES   = `ACTIVE_LINES,
    parameter int VBLANK   = `VBLANK_MIN_LINES,
    parameter int PORCH    = `HSYNC_MIN_CLKS,
    parameter int RST_HOLD = 400
) (
    // link clock from the bench
    input  wire logic        i_pixel_clock,
    // pins driven towards the device
    output logic             o_reset_n,
    output logic [23:0]      o_pixel_bus,
    output logic             o_pixel_valid,
    output logic             o_hsync
);
    initial begin
        o_reset_n     = 1'b0;
        o_pixel_bus   = 24'h000000;
        o_pixel_valid = 1'b0;
        o_hsync       = 1'b0;
    end
    // bus toggles while idle so an ignored word never looks stable
    task automatic idle(input int n);
        repeat (n) begin
            o_pixel_bus = ~o_pixel_bus;
            @(negedge i_pixel_clock);
        end
    endtask
    // clock already runs through the hold, so release sees a stable clock
    task automatic power_up();
        @(negedge i_pixel_clock);
        o_reset_n = 1'b0;
        idle(RST_HOLD);
        o_reset_n = 1'b1;
    endtask
    task automatic send_line(input int n);
        @(negedge i_pixel_clock);
        o_hsync = 1'b1;
        idle(PORCH);
        o_hsync = 1'b0;
        idle(PORCH);
        for (int k = 0; k < n; k++) begin
            o_pixel_valid = 1'b1;
            o_pixel_bus   = {~8'(k), 8'(k) ^ 8'h5a, 8'(k)};
            @(negedge i_pixel_clock);
        end
        o_pixel_valid = 1'b0;
        idle(PORCH);
    endtask
    // shortened frame: fewer active lines, minimum blanking
    task automatic send_frame();
        repeat (NLINES) send_line(NPIX);
        repeat (VBLANK) send_line(0);
    endtask
endmodule
`default_nettype wire
